// ===== design/sff_byte_store.sv
// Byte array holding the stored frames
`timescale 1ns/1ps
module sff_byte_store #(
  parameter int DEPTH = 1024  // Bytes held
) (
  input  logic                     clk,
  input  logic                     we,
  input  logic [$clog2(DEPTH)-1:0] waddr,
  input  logic [7:0]               wdata,
  input  logic [$clog2(DEPTH)-1:0] raddrA,
  output logic [7:0]               rdataA,
  input  logic [$clog2(DEPTH)-1:0] raddrB,
  output logic [7:0]               rdataB
);
  // Addresses wrap by bit width, so only powers of two are served
  if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_depth_chk
    $error("DEPTH must be a power of two");
  end

  // ==========================================================
  // Storage
  logic [7:0] mem [DEPTH];  // No reset: pointers define validity

  // One write per cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Port A feeds the reader, port B peeks at the oldest frame
  assign rdataA = mem[raddrA];
  assign rdataB = mem[raddrB];
endmodule

// ===== design/sff_frame_fifo.sv
// Sensor frame FIFO: frame builder, byte store control and host read port
`timescale 1ns/1ps
module sff_frame_fifo #(
  parameter int DEPTH = sff_pkg::FIFO_BYTES  // Storage in bytes
) (
  input  logic                 clk,
  input  logic                 reset,
  input  sff_pkg::sff_reg_req_t regReq,      // Host register access
  input  logic                 readDone,     // End of a read operation
  output logic [7:0]           regRdData,    // Read data, cycle after rd
  output logic                 regRdValid,
  input  sff_pkg::sff_samples_t samples,     // Sensor samples and strobes
  input  logic [23:0]          senseTime,    // Running sensortime
  input  logic                 eventPinOne,
  input  logic                 eventPinTwo,
  input  logic [1:0]           tagPinReady   // Pin configured as input
);
  import sff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] sff_ptr_t;

  if (DEPTH < 64 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("DEPTH must be a power of two, at least 64");
  end

  // ==========================================================
  // Register decode
  wire       dataRd     = regReq.rd && (regReq.addr == ADDR_DATA);
  wire       wrDecim    = regReq.wr && (regReq.addr == ADDR_DECIM);
  wire       wrSrcLo    = regReq.wr && (regReq.addr == ADDR_SRC_LO);
  wire       wrSrcHi    = regReq.wr && (regReq.addr == ADDR_SRC_HI);
  wire       flushCmd   = regReq.wr && (regReq.addr == ADDR_CMD) &&
                          (regReq.wdata == CMD_FLUSH);
  logic [7:0] decim_r;                     // Decimation setup
  logic [7:0] srcLo_r;                     // Source select, low byte
  logic [7:0] srcHi_r;                     // Source select, high byte
  wire       headerMode = srcHi_r[SRC_HDR_BIT];
  wire [2:0] senEn      = {srcHi_r[SRC_MAG_BIT], srcHi_r[SRC_GYR_BIT],
                           srcHi_r[SRC_ACC_BIT]};
  wire [2:0] newEn      = {regReq.wdata[SRC_MAG_BIT], regReq.wdata[SRC_GYR_BIT],
                           regReq.wdata[SRC_ACC_BIT]};
  // A mode flip, or a sensor change without headers, leaves unparsable data
  wire       autoFlush  = wrSrcHi && ((regReq.wdata[SRC_HDR_BIT] != headerMode) ||
                          (!headerMode && newEn != senEn));
  wire       clearAll   = flushCmd || autoFlush;

  // Setup registers; a flush leaves them alone
  always_ff @(posedge clk) begin
    if (reset) begin
      decim_r <= DECIM_RST;
      srcLo_r <= SRC_LO_RST;
      srcHi_r <= SRC_HI_RST;
    end else begin
      if (wrDecim) decim_r <= regReq.wdata;
      if (wrSrcLo) srcLo_r <= regReq.wdata;
      if (wrSrcHi) srcHi_r <= regReq.wdata;
    end
  end

  // ==========================================================
  // Config-change frame pending
  wire       accChg  = wrDecim && (regReq.wdata[ACC_FLD_LSB +: 4] != decim_r[ACC_FLD_LSB +: 4]);
  wire       gyrChg  = wrDecim && (regReq.wdata[GYR_FLD_LSB +: 4] != decim_r[GYR_FLD_LSB +: 4]);
  wire       cfgTrig = headerMode && (accChg || gyrChg || (wrSrcHi && newEn != senEn));
  wire [7:0] cfgNew  = (accChg ? CFG_ACC_CONF : 8'h00) | (gyrChg ? CFG_GYR_CONF : 8'h00);
  logic       cfgPend_r;                   // A config frame is owed
  logic [7:0] cfgByte_r;                   // Its change bits
  sff_wstate_t wState_r;                   // Frame writer state
  sff_wstate_t wState_nxt;
  wire       cfgDone = (wState_r == W_CFGD);
  wire       cfgGo   = cfgPend_r && headerMode;

  // A new change in the cycle the frame goes out is kept
  always_ff @(posedge clk) begin
    if (reset || clearAll) begin
      cfgPend_r <= 1'b0;
      cfgByte_r <= 8'h00;
    end else begin
      cfgPend_r <= cfgTrig || (cfgPend_r && !cfgDone);
      cfgByte_r <= (cfgDone ? 8'h00 : cfgByte_r) | cfgNew;
    end
  end

  // ==========================================================
  // Decimation, one channel per accel and gyro
  wire [1:0] filtRdy = {samples.gyrRdy, samples.accRdy};
  wire [1:0] rawRdy  = {samples.gyrRawRdy, samples.accRawRdy};
  logic [1:0] keep;                        // Sample survives decimation
  logic [1:0] useRaw;                      // Unfiltered source chosen
  for (genvar i = 0; i < 2; i++) begin : g_dec
    logic [6:0] cnt_r;                     // Samples seen since flush
    wire [3:0] fld  = (i == 0) ? decim_r[ACC_FLD_LSB +: 4] : decim_r[GYR_FLD_LSB +: 4];
    wire       rdy  = fld[DWN_RAW_BIT] ? rawRdy[i] : filtRdy[i];
    wire [6:0] mask = 7'((8'h01 << fld[2:0]) - 8'h01);
    assign keep[i]   = rdy && ((cnt_r & mask) == 7'h00);
    assign useRaw[i] = fld[DWN_RAW_BIT];
    // Counts every strobe; only plain dropping, no averaging
    always_ff @(posedge clk) begin
      if (reset || clearAll) cnt_r <= 7'h00;
      else if (rdy) cnt_r <= cnt_r + 7'h01;
    end
  end

  // ==========================================================
  // Latest sample of each sensor
  logic [47:0] accD_r;
  logic [47:0] gyrD_r;
  logic [63:0] magD_r;
  wire  [2:0]  fresh = {samples.magRdy, keep} & senEn;

  always_ff @(posedge clk) begin
    if (reset) begin
      accD_r <= 48'h0;
      gyrD_r <= 48'h0;
      magD_r <= 64'h0;
    end else begin
      if (keep[0]) accD_r <= useRaw[0] ? samples.accRaw : samples.acc;
      if (keep[1]) gyrD_r <= useRaw[1] ? samples.gyrRaw : samples.gyr;
      if (samples.magRdy) magD_r <= samples.mag;
    end
  end

  // ==========================================================
  // Frame writer
  logic [2:0]   parm_r;                    // Sensors in this frame
  logic [159:0] pay_r;                     // Payload, next byte lowest
  logic [159:0] payNew;
  logic [4:0]   left_r;                    // Payload bytes still to write
  logic [1:0]   tagHold_r;                 // Pin events awaiting a header
  sff_ptr_t     wrPtr_r;                   // Next byte written
  sff_ptr_t     commit_r;                  // End of complete frames
  sff_ptr_t     start_r;                   // Oldest frame, also read base
  sff_ptr_t     rdPtr_r;                   // Next byte read
  logic [7:0]   memRd;
  logic [7:0]   memHead;
  wire  [4:0]   payLen  = sff_frame_len(8'h00, 1'b0, parm_r);
  wire  [4:0]   needLen = payLen + (headerMode ? 5'd1 : 5'd0) + (cfgGo ? CTL_LEN : 5'd0);
  wire  [4:0]   headLen = sff_frame_len(memHead, headerMode, senEn);
  wire  sff_ptr_t used    = wrPtr_r - start_r;
  wire  sff_ptr_t free    = sff_ptr_t'(DEPTH) - used;
  wire  roomOk  = free >= sff_ptr_t'(needLen);
  wire  dropGo  = (wState_r == W_ROOM) && !roomOk && !dataRd && !readDone;
  wire  [1:0]   tagEn   = {srcHi_r[SRC_TAG2_BIT], srcHi_r[SRC_TAG1_BIT]} & tagPinReady;
  wire  sff_header_t hdrNow = '{kind: KIND_REG, parm: {1'b0, parm_r}, ext: tagHold_r};
  wire  memWe   = (wState_r == W_CFGH) || (wState_r == W_CFGD) ||
                  (wState_r == W_HDR) || (wState_r == W_DATA);
  wire  [7:0]   memWdata = (wState_r == W_CFGH) ? HDR_CFG :
                           (wState_r == W_CFGD) ? cfgByte_r :
                           (wState_r == W_HDR)  ? hdrNow :
                           pay_r[7:0];

  // Pack present sensors: mag first, then gyro, then accel
  always_comb begin
    payNew = {112'h0, parm_r[0] ? accD_r : 48'h0};
    if (parm_r[1]) payNew = {payNew[111:0], gyrD_r};
    if (parm_r[2]) payNew = {payNew[95:0], magD_r};
  end

  // Writer sequencing; the header is skipped without header mode
  always_comb begin
    wState_nxt = wState_r;
    case (wState_r)
      W_IDLE: if (|fresh) wState_nxt = W_ROOM;
      W_ROOM: if (roomOk) wState_nxt = cfgGo ? W_CFGH : (headerMode ? W_HDR : W_DATA);
      W_CFGH: wState_nxt = W_CFGD;
      W_CFGD: wState_nxt = W_HDR;
      W_HDR:  wState_nxt = W_DATA;
      W_DATA: if (left_r == 5'd1) wState_nxt = W_IDLE;
      default: wState_nxt = W_IDLE;
    endcase
  end

  // Writer registers; a frame becomes readable only when complete
  always_ff @(posedge clk) begin
    if (reset || clearAll) begin
      wState_r <= W_IDLE;
      wrPtr_r  <= '0;
      commit_r <= '0;
      parm_r   <= 3'h0;
      pay_r    <= '0;
      left_r   <= 5'd0;
    end else begin
      wState_r <= wState_nxt;
      if (wState_r == W_IDLE && |fresh) parm_r <= headerMode ? fresh : senEn;
      if (wState_r == W_ROOM) begin
        pay_r  <= payNew;
        left_r <= payLen;
      end
      if (wState_r == W_DATA) begin
        pay_r  <= pay_r >> 8;
        left_r <= left_r - 5'd1;
      end
      if (memWe) wrPtr_r <= wrPtr_r + 1'b1;
      if (cfgDone || (wState_r == W_DATA && left_r == 5'd1)) commit_r <= wrPtr_r + 1'b1;
    end
  end

  // Pin events stick until a header carries them; set beats clear
  always_ff @(posedge clk) begin
    if (reset || clearAll) tagHold_r <= 2'b00;
    else tagHold_r <= (tagHold_r & {2{wState_r != W_HDR}}) |
                      ({eventPinTwo, eventPinOne} & tagEn & {2{headerMode}});
  end

  sff_byte_store #(.DEPTH(DEPTH)) u_store (
    .clk    (clk),
    .we     (memWe),
    .waddr  (wrPtr_r[AW-1:0]),
    .wdata  (memWdata),
    .raddrA (rdPtr_r[AW-1:0]),
    .rdataA (memRd),
    .raddrB (start_r[AW-1:0]),
    .rdataB (memHead)
  );

  // ==========================================================
  // Reader
  logic [4:0]  rdLeft_r;                   // Bytes left of frame in reading
  logic [7:0]  skipCnt_r;                  // Frames dropped since readout
  logic        skipPh_r;                   // Skip header already shown
  logic [2:0]  timePh_r;                   // Sensortime frame progress
  logic [23:0] timeCap_r;                  // Time at last frame read
  logic [7:0]  regRdData_r;
  logic        regRdValid_r;
  wire  skipPend = headerMode && (skipCnt_r != 8'h00);
  wire  timeOn   = headerMode && srcHi_r[SRC_TIME_BIT] && (timePh_r < TIME_PHASES);
  wire  [4:0] readLen = sff_frame_len(memRd, headerMode, senEn);
  wire  sff_rsrc_t rSrc = skipPh_r ? R_SKIPC :
                          (skipPend && rdLeft_r == 5'd0) ? R_SKIPH :
                          (rdPtr_r != commit_r) ? R_MEM :
                          timeOn ? R_TIME : R_EMPTY;
  wire  [7:0] timeByte = (timePh_r == 3'd1) ? timeCap_r[7:0] :
                         (timePh_r == 3'd2) ? timeCap_r[15:8] : timeCap_r[23:16];
  wire  [7:0] rdByte   = (rSrc == R_SKIPH) ? HDR_SKIP :
                         (rSrc == R_SKIPC) ? skipCnt_r :
                         (rSrc == R_MEM)   ? memRd :
                         (rSrc == R_TIME)  ? ((timePh_r == 3'd0) ? HDR_TIME : timeByte) :
                         HDR_EMPTY;
  wire  [15:0] lvl     = 16'(commit_r - start_r) + (skipPend ? 16'(CTL_LEN) : 16'h0000);
  wire  [7:0] rdMux    = (regReq.addr == ADDR_LEN_LO) ? lvl[7:0] :
                         (regReq.addr == ADDR_LEN_HI) ? lvl[15:8] :
                         (regReq.addr == ADDR_DATA)   ? rdByte :
                         (regReq.addr == ADDR_DECIM)  ? decim_r :
                         (regReq.addr == ADDR_SRC_LO) ? srcLo_r :
                         (regReq.addr == ADDR_SRC_HI) ? srcHi_r : 8'h00;

  // Read pointers; the end of a read operation rewinds to the frame start
  always_ff @(posedge clk) begin
    if (reset || clearAll) begin
      start_r   <= '0;
      rdPtr_r   <= '0;
      rdLeft_r  <= 5'd0;
      skipCnt_r <= 8'h00;
      skipPh_r  <= 1'b0;
      timePh_r  <= 3'd0;
      timeCap_r <= 24'h0;
    end else if (readDone) begin
      rdPtr_r  <= start_r;
      rdLeft_r <= 5'd0;
      skipPh_r <= 1'b0;
      timePh_r <= 3'd0;
    end else if (dropGo) begin
      start_r   <= start_r + sff_ptr_t'(headLen);
      rdPtr_r   <= start_r + sff_ptr_t'(headLen);
      rdLeft_r  <= 5'd0;
      skipCnt_r <= (skipCnt_r == SKIP_MAX) ? SKIP_MAX : skipCnt_r + 8'h01;
    end else if (dataRd) begin
      case (rSrc)
        R_SKIPH: skipPh_r <= 1'b1;
        R_SKIPC: begin
          skipPh_r  <= 1'b0;
          skipCnt_r <= 8'h00;
        end
        R_MEM: begin
          rdPtr_r  <= rdPtr_r + 1'b1;
          rdLeft_r <= (rdLeft_r == 5'd0) ? readLen - 5'd1 : rdLeft_r - 5'd1;
          if (rdLeft_r == 5'd1) begin
            start_r   <= rdPtr_r + 1'b1;
            timeCap_r <= senseTime;
            timePh_r  <= 3'd0;
          end
        end
        R_TIME: timePh_r <= timePh_r + 3'd1;
        default: ;
      endcase
    end
  end

  // Registered read answer
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData_r  <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      if (regReq.rd) regRdData_r <= rdMux;
      regRdValid_r <= regReq.rd;
    end
  end

  assign regRdData  = regRdData_r;
  assign regRdValid = regRdValid_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sSkipHdr;
    dataRd && !readDone && rSrc == R_SKIPH;
  endsequence
  sequence sTimeHdr;
    dataRd && !readDone && rSrc == R_TIME && timePh_r == 3'd0;
  endsequence
  // Last time byte; reads may be spaced, so no fixed gap is assumed
  sequence sTimeRest;
    dataRd && !readDone && rSrc == R_TIME && timePh_r == 3'd3;
  endsequence

  a_fill_bound: assert property ((commit_r - start_r) <= sff_ptr_t'(DEPTH))
    else $error("stored bytes exceed capacity");
  a_kind_legal: assert property (memWe && (wState_r == W_HDR || wState_r == W_CFGH)
    |-> memWdata[7:6] == KIND_REG || memWdata[7:6] == KIND_CTL)
    else $error("reserved frame kind written");
  a_reg_header: assert property (wState_r == W_HDR
    |-> memWdata[7:6] == KIND_REG && memWdata[5:2] != 4'h0)
    else $error("bad sensor frame header");
  a_nohdr_frame: assert property (!headerMode && wState_r == W_ROOM && roomOk && !clearAll
    |=> wState_r == W_DATA && left_r == $past(payLen) && left_r != 5'd0)
    else $error("headerless frame malformed");
  a_overread_magic: assert property (dataRd && !readDone && !headerMode && rSrc == R_EMPTY
    |=> regRdValid && regRdData == HDR_EMPTY)
    else $error("overread did not return 0x80");
  a_skip_frame: assert property (sSkipHdr |=> regRdData == HDR_SKIP && rSrc == R_SKIPC)
    else $error("skip frame malformed");
  a_time_head: assert property (sTimeHdr |=> regRdData == HDR_TIME)
    else $error("sensortime header wrong");
  a_time_frame: assert property (sTimeRest
    |=> regRdData == $past(timeCap_r[23:16]))
    else $error("sensortime bytes wrong");
  a_cfg_first: assert property (cfgGo && wState_r == W_ROOM && roomOk
    |=> wState_r == W_CFGH ##1 wState_r == W_CFGD ##1 wState_r == W_HDR)
    else $error("config frame not ahead of data");
  a_drop_oldest: assert property (dropGo && !clearAll
    |=> start_r == $past(start_r) + sff_ptr_t'($past(headLen)))
    else $error("oldest frame not dropped");
  a_rewind: assert property (readDone && !clearAll |=> rdPtr_r == $past(start_r))
    else $error("partial frame not rewound");
  a_flush_empty: assert property (flushCmd |=> lvl == 16'h0000 && $stable(decim_r))
    else $error("flush did not empty");
  a_reset_empty: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> lvl == 16'h0000 && skipCnt_r == 8'h00)
    else $error("reset did not empty");
endmodule

// ===== design/sff_pkg.sv
// Constants and carrier types for the sensor frame FIFO
package sff_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_LEN_LO  = 8'h22;  // Fill level, low byte
  localparam logic [7:0] ADDR_LEN_HI  = 8'h23;  // Fill level, high byte
  localparam logic [7:0] ADDR_DATA    = 8'h24;  // Frame read port
  localparam logic [7:0] ADDR_DECIM   = 8'h45;  // Decimation setup
  localparam logic [7:0] ADDR_SRC_LO  = 8'h46;  // Source select, low byte
  localparam logic [7:0] ADDR_SRC_HI  = 8'h47;  // Source select, high byte
  localparam logic [7:0] ADDR_CMD     = 8'h7e;  // Command register
  localparam logic [7:0] CMD_FLUSH    = 8'hb0;  // Empties the store

  // Reset values of the setup registers
  localparam logic [7:0] DECIM_RST    = 8'h00;
  localparam logic [7:0] SRC_LO_RST   = 8'h00;
  localparam logic [7:0] SRC_HI_RST   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int ACC_FLD_LSB   = 4;  // Accel decimation field [7:4]
  localparam int GYR_FLD_LSB   = 0;  // Gyro decimation field [3:0]
  localparam int DWN_RAW_BIT   = 3;  // Within a field: take unfiltered data
  localparam int SRC_TIME_BIT  = 1;  // Sensortime frames enabled
  localparam int SRC_TAG2_BIT  = 2;  // Tag from event pin two
  localparam int SRC_TAG1_BIT  = 3;  // Tag from event pin one
  localparam int SRC_HDR_BIT   = 4;  // Header mode
  localparam int SRC_MAG_BIT   = 5;  // Magnetometer stored
  localparam int SRC_ACC_BIT   = 6;  // Accelerometer stored
  localparam int SRC_GYR_BIT   = 7;  // Gyroscope stored

  // ==========================================================
  // Frame format
  localparam logic [1:0] KIND_REG     = 2'b10;  // Sensor-data frame
  localparam logic [1:0] KIND_CTL     = 2'b01;  // Control frame
  localparam logic [3:0] PARM_SKIP    = 4'h0;
  localparam logic [3:0] PARM_TIME    = 4'h1;
  localparam logic [3:0] PARM_CFG     = 4'h2;
  localparam logic [7:0] HDR_SKIP     = {KIND_CTL, PARM_SKIP, 2'b00};
  localparam logic [7:0] HDR_TIME     = {KIND_CTL, PARM_TIME, 2'b00};
  localparam logic [7:0] HDR_CFG      = {KIND_CTL, PARM_CFG, 2'b00};
  localparam logic [7:0] HDR_EMPTY    = 8'h80;  // Marks no valid frame
  localparam logic [7:0] SKIP_MAX     = 8'hff;  // Skip count saturates
  localparam logic [7:0] CFG_ACC_CONF = 8'h01;  // Accel setup changed
  localparam logic [7:0] CFG_GYR_CONF = 8'h04;  // Gyro setup changed
  localparam logic [4:0] MAG_BYTES    = 5'd8;
  localparam logic [4:0] GYR_BYTES    = 5'd6;
  localparam logic [4:0] ACC_BYTES    = 5'd6;
  localparam logic [4:0] CTL_LEN      = 5'd2;   // Stored control frame
  localparam logic [2:0] TIME_PHASES  = 3'd4;   // Header plus three bytes
  localparam int         FIFO_BYTES   = 1024;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] parm;
    logic [1:0] ext;
  } sff_header_t;

  typedef struct packed {
    logic       wr;     // Register write strobe
    logic       rd;     // Register read strobe
    logic [7:0] addr;
    logic [7:0] wdata;
  } sff_reg_req_t;

  typedef struct packed {
    logic        magRdy;
    logic        gyrRdy;
    logic        gyrRawRdy;
    logic        accRdy;
    logic        accRawRdy;
    logic [63:0] mag;
    logic [47:0] gyr;
    logic [47:0] gyrRaw;
    logic [47:0] acc;
    logic [47:0] accRaw;
  } sff_samples_t;

  typedef enum logic [2:0] {W_IDLE, W_ROOM, W_CFGH, W_CFGD, W_HDR, W_DATA} sff_wstate_t;
  typedef enum logic [2:0] {R_SKIPH, R_SKIPC, R_MEM, R_TIME, R_EMPTY} sff_rsrc_t;

  // Total stored length of the frame that starts with byte hdr
  function automatic logic [4:0] sff_frame_len(input logic [7:0] hdr,
                                               input logic       hm,
                                               input logic [2:0] en);
    logic [2:0] s;
    logic [4:0] n;
    s = hm ? hdr[4:2] : en;
    n = (s[2] ? MAG_BYTES : 5'd0) + (s[1] ? GYR_BYTES : 5'd0) + (s[0] ? ACC_BYTES : 5'd0);
    if (hm && hdr[7:6] == KIND_CTL) n = CTL_LEN;
    else if (hm) n = n + 5'd1;
    return n;
  endfunction

endpackage

// ===== test/sff_frame_fifo_test.sv
// Self-checking bench for the sensor frame FIFO
`timescale 1ns/1ps
module sff_frame_fifo_test;
  import sff_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  sff_samples_t samples = '0;
  logic [23:0]  senseTime = 24'h000000;
  logic         eventPinOne = 1'b0;
  logic         eventPinTwo = 1'b0;
  logic [1:0]   tagPinReady = 2'b00;
  sff_reg_req_t regReq;
  logic         readDone;
  logic         regRdValid;
  logic [7:0]   regRdData;
  logic [7:0]   q;
  logic [7:0]   expQ[$];  // Bytes the host should see next
  int           bad_count = 0;
  int           tests_run = 0;
  int           cycles = 0;
  int           seed = 81456;
  logic         pinRand = 1'b1;  // Random pin levels until the tag scenario
  always #4 clk = ~clk;
  // Pins toggle randomly while tag enables are off; the tag scenario fixes them
  always @(negedge clk)
    if (pinRand) {eventPinTwo, eventPinOne, tagPinReady} <= 4'($random(seed));
  sff_frame_fifo sff_frame_fifo_inst (.clk(clk), .reset(reset), .regReq(regReq),
    .readDone(readDone), .regRdData(regRdData), .regRdValid(regRdValid),
    .samples(samples), .senseTime(senseTime), .eventPinOne(eventPinOne),
    .eventPinTwo(eventPinTwo), .tagPinReady(tagPinReady));
  sff_host_model sff_host_model_inst (.clk(clk), .regReq(regReq), .readDone(readDone),
    .regRdData(regRdData), .regRdValid(regRdValid));
  function automatic logic [63:0] rnd();
    return {$random(seed), $random(seed)};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sff_host_model_inst.access(1'b1, a, d, q);
  endtask
  task automatic lvl(input logic [15:0] e);
    sff_host_model_inst.access(1'b0, ADDR_LEN_LO, 8'h00, q);
    chk(q, e[7:0]);
    sff_host_model_inst.access(1'b0, ADDR_LEN_HI, 8'h00, q);
    chk(q, e[15:8]);
  endtask
  // Burst read compared with the model queue
  task automatic drain(input int n);
    repeat (n) begin
      sff_host_model_inst.access(1'b0, ADDR_DATA, 8'h00, q);
      chk(q, expQ.pop_front());
    end
  endtask
  task automatic put(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) expQ.push_back(v[8*i+:8]);
  endtask
  // Strobe mask {mag,gyr,gyrRaw,acc,accRaw}; gap leaves the writer idle
  task automatic strobe(input logic [4:0] m);
    @(negedge clk);
    samples = {m, rnd(), 48'(rnd()), 48'(rnd()), 48'(rnd()), 48'(rnd())};
    @(negedge clk);
    samples[$bits(sff_samples_t)-1 -: 5] = 5'b0;
    repeat (30) @(negedge clk);
  endtask
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    senseTime = 24'(rnd());
    repeat (16) @(negedge clk);
    reset = 1'b0;
    lvl(16'h0000);
    expQ = {HDR_EMPTY};
    drain(1);
    // Headerless, accel only
    wr(ADDR_SRC_HI, 8'h40);
    strobe(5'b00010);
    lvl(16'h0006);
    put(samples.acc, 6);
    expQ.push_back(HDR_EMPTY);
    drain(7);
    // Decimate accel by two: half the strobes kept
    wr(ADDR_DECIM, 8'h10);
    repeat (4) strobe(5'b00010);
    lvl(16'h000c);
    wr(ADDR_CMD, CMD_FLUSH);
    lvl(16'h0000);
    sff_host_model_inst.access(1'b0, ADDR_SRC_HI, 8'h00, q);
    chk(q, 8'h40);
    wr(ADDR_DECIM, 8'h00);
    // Header mode with gyro, accel and sensortime frames
    wr(ADDR_SRC_HI, 8'h10);
    wr(ADDR_SRC_HI, 8'hd2);
    strobe(5'b01010);
    expQ = {HDR_CFG, 8'h00, 8'h8c};
    put(samples.gyr, 6);
    put(samples.acc, 6);
    expQ.push_back(HDR_TIME);
    put(senseTime, 3);
    expQ.push_back(HDR_EMPTY);
    lvl(16'd15);
    drain(3);
    sff_host_model_inst.done();
    expQ.push_front(8'h8c);
    drain(18);
    // Overflow: 200 accel frames of 7 bytes
    wr(ADDR_SRC_HI, 8'h50);
    repeat (200) strobe(5'b00010);
    lvl(16'd1024);
    expQ = {HDR_SKIP, 8'd55, 8'h84};
    drain(3);
    wr(ADDR_CMD, CMD_FLUSH);
    lvl(16'h0000);
    // Header mode with pin tags, magnetometer and unfiltered accel
    pinRand = 1'b0;
    @(negedge clk);
    {eventPinTwo, eventPinOne, tagPinReady} = 4'b0111;
    wr(ADDR_DECIM, 8'h80);
    wr(ADDR_SRC_HI, 8'h7c);
    strobe(5'b10001);
    lvl(16'd17);
    expQ = {HDR_CFG, 8'h01, 8'h95};
    put(samples.mag, 8);
    put(samples.accRaw, 6);
    expQ.push_back(HDR_EMPTY);
    drain(18);
    final_report();
  end
endmodule

// ===== test/sff_host_model.sv
// Host model: issues register reads and writes and ends read operations
`timescale 1ns/1ps
module sff_host_model (
  input  logic                  clk,
  output sff_pkg::sff_reg_req_t regReq,
  output logic                  readDone,
  input  logic [7:0]            regRdData,
  input  logic                  regRdValid
);
  import sff_pkg::*;
  initial begin
    regReq = '0;
    readDone = 1'b0;
  end
  // One access; request held across exactly one rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    regReq = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    // A missing answer shows up as unknown data in the caller's compare
    q = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    regReq = '0;
  endtask
  // Chip-select release ends the read operation
  task automatic done();
    @(negedge clk);
    readDone = 1'b1;
    @(negedge clk);
    readDone = 1'b0;
  endtask
endmodule
